// [rtl/flcsr_cfg.svh]
// offsets, field positions, reset values and counts for the register bank
// assumes inclusion by bare name from the package and design modules
`ifndef FLCSR_CFG_SVH
`define FLCSR_CFG_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define FLCSR_IDX_FIFO_LEVELS 10'h001
`define FLCSR_IDX_COL_FIRST 10'h002
`define FLCSR_IDX_COL_LAST 10'h003
`define FLCSR_IDX_LINE_FIRST 10'h004
`define FLCSR_IDX_LINE_LAST 10'h005
`define FLCSR_IDX_ENERGY_BASE 10'h080
`define FLCSR_IDX_ENERGY_LAST 10'h0A9
`define FLCSR_IDX_LUMA_SUM 10'h0AA
`define FLCSR_IDX_BLUE_SUM 10'h0AB
`define FLCSR_IDX_RED_SUM 10'h0AC
`define FLCSR_IDX_LUMA_MIN 10'h0AD
`define FLCSR_IDX_LUMA_MAX 10'h0AE

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define FLCSR_ENC_LEVEL_LSB 0
`define FLCSR_ENC_LEVEL_MSB 3
`define FLCSR_DEC_LEVEL_LSB 4
`define FLCSR_DEC_LEVEL_MSB 7
`define FLCSR_ENC_LEVEL_RESET 4'h8
`define FLCSR_DEC_LEVEL_RESET 4'h8
`define FLCSR_COL_FIRST_RESET 10'h000
`define FLCSR_COL_LAST_RESET 10'h3FF
`define FLCSR_LINE_FIRST_RESET 10'h000
`define FLCSR_LINE_LAST_RESET 10'h3FF

// ****************************************************************
// fifo, video standard and statistics counts, black levels
// ****************************************************************
`define FLCSR_FIFO_DEPTH 512
`define FLCSR_LEVEL_STEP_SHIFT 5
`define FLCSR_COL_MAX 10'h2CF
`define FLCSR_LINES_525 10'h20D
`define FLCSR_LINES_625 10'h271
`define FLCSR_ENERGY_BLOCKS 42
`define FLCSR_BLACK_LUMA 8'h10
`define FLCSR_BLACK_CHROMA 8'h00

`endif

// [rtl/flcsr_pkg.sv]
// types shared by the register bank and its helper modules
// assumes flcsr_cfg.svh on the include path
`include "flcsr_cfg.svh"

package flcsr_pkg;

    // ****************************************************************
    // pixel component and value types
    // ****************************************************************
    typedef enum logic [1:0] {
        FLCSR_COMP_LUMA = 2'h0,
        FLCSR_COMP_BLUE = 2'h1,
        FLCSR_COMP_RED = 2'h3
    } flcsr_comp_type;

    typedef logic [15:0] flcsr_code_type;
    typedef logic [9:0] flcsr_coord_type;

endpackage : flcsr_pkg

// [rtl/flcsr_luma_range.sv]
// tracks least and greatest luma of the unprocessed input over one field
// assumes pixel inputs already on CLK; field_start is a one-cycle pulse
module flcsr_luma_range #(
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic field_start,
    input wire logic pix_valid,
    input wire flcsr_pkg::flcsr_comp_type pix_comp,
    input wire logic [DATA_W-1:0] pix_data,
    output flcsr_pkg::flcsr_code_type luma_min,
    output flcsr_pkg::flcsr_code_type luma_max
);
    import flcsr_pkg::*;

    logic [DATA_W-1:0] run_min;
    logic [DATA_W-1:0] run_max;
    logic [DATA_W-1:0] next_min;
    logic [DATA_W-1:0] next_max;
    wire take = pix_valid && (pix_comp == FLCSR_COMP_LUMA);

    // running extremes, a new field restarts from the first sample
    assign next_min = (take && (pix_data < run_min)) ? pix_data : run_min;
    assign next_max = (take && (pix_data > run_max)) ? pix_data : run_max;

    // publish the finished field and restart the running extremes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_min <= '1;
            run_max <= '0;
            luma_min <= 16'h0000;
            luma_max <= 16'h0000;
        end else if (field_start) begin
            luma_min <= 16'(run_min);
            luma_max <= 16'(run_max);
            run_min <= take ? pix_data : '1;
            run_max <= take ? pix_data : '0;
        end else begin
            run_min <= next_min;
            run_max <= next_max;
        end
    end

endmodule : flcsr_luma_range

// [rtl/flcsr_crop.sv]
// blanks pixels outside the active window to black during encode
// assumes window bounds already clamped and pixel inputs on CLK
`include "flcsr_cfg.svh"
module flcsr_crop #(
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic encode,
    input wire flcsr_pkg::flcsr_coord_type col_first,
    input wire flcsr_pkg::flcsr_coord_type col_last,
    input wire flcsr_pkg::flcsr_coord_type line_first,
    input wire flcsr_pkg::flcsr_coord_type line_last,
    input wire logic pix_valid,
    input wire flcsr_pkg::flcsr_coord_type pix_col,
    input wire flcsr_pkg::flcsr_coord_type pix_line,
    input wire flcsr_pkg::flcsr_comp_type pix_comp,
    input wire logic [DATA_W-1:0] pix_data,
    output logic out_valid,
    output flcsr_pkg::flcsr_comp_type out_comp,
    output logic [DATA_W-1:0] out_data
);
    import flcsr_pkg::*;

    wire logic [DATA_W-1:0] black_luma = DATA_W'(`FLCSR_BLACK_LUMA);
    wire logic [DATA_W-1:0] black_chroma = DATA_W'(`FLCSR_BLACK_CHROMA);
    // columns count from 0, lines from 1 including blanking; bounds inclusive
    wire col_in = (pix_col >= col_first) && (pix_col <= col_last);
    wire line_in = (pix_line >= line_first) && (pix_line <= line_last);
    wire blank = encode && !(col_in && line_in);
    wire logic [DATA_W-1:0] black = (pix_comp == FLCSR_COMP_LUMA) ? black_luma : black_chroma;

    // one stage; the pixel count and timing are never changed, only values
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_valid <= 1'b0;
            out_comp <= FLCSR_COMP_LUMA;
            out_data <= '0;
        end else begin
            out_valid <= pix_valid;
            out_comp <= pix_comp;
            out_data <= blank ? black : pix_data;
        end
    end

endmodule : flcsr_crop

// [rtl/flcsr_regs.sv]
// indirect register bank: fifo service levels, active window, field statistics
// assumes all inputs on CLK; REG_WRITE and REG_READ are one-cycle strobes
`include "flcsr_cfg.svh"

module flcsr_regs #(
    parameter int DATA_W = 8,
    parameter int FIFO_DEPTH = `FLCSR_FIFO_DEPTH,
    parameter int ENERGY_BLOCKS = `FLCSR_ENERGY_BLOCKS
) (
    input wire logic CLK,
    input wire logic RESET,
    // indirect register access
    input wire logic [9:0] REG_INDEX,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WRITE,
    input wire logic REG_READ,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic STATUS_READ,
    // mode and fifo state
    input wire logic ENCODE_MODE,
    input wire logic MODE_625,
    input wire logic [9:0] FIFO_FILL,
    output logic FIFO_SERVICE_REQUEST_PIN,
    output logic FIFO_SERVICE_REQUEST_FLAG,
    // statistics from the transform
    input wire logic ENERGY_VALID,
    input wire logic [5:0] ENERGY_BLOCK,
    input wire logic [47:0] ENERGY_SUM,
    input wire logic STATS_REFRESH,
    input wire flcsr_pkg::flcsr_code_type LUMA_SUM_IN,
    input wire flcsr_pkg::flcsr_code_type BLUE_SUM_IN,
    input wire flcsr_pkg::flcsr_code_type RED_SUM_IN,
    output logic STATS_READY_PIN,
    output logic STATS_READY_STATUS,
    // pixel stream
    input wire logic FIELD_START,
    input wire logic PIX_VALID,
    input wire flcsr_pkg::flcsr_coord_type PIX_COL,
    input wire flcsr_pkg::flcsr_coord_type PIX_LINE,
    input wire flcsr_pkg::flcsr_comp_type PIX_COMP,
    input wire logic [DATA_W-1:0] PIX_DATA,
    output logic PIX_OUT_VALID,
    output flcsr_pkg::flcsr_comp_type PIX_OUT_COMP,
    output logic [DATA_W-1:0] PIX_OUT_DATA
);
    import flcsr_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************

    // selects the sixteen significant bits of a block's wide energy sum
    function automatic flcsr_code_type energy_code(input logic [5:0] block, input logic [47:0] sum);
        flcsr_code_type code;
        code = 16'h0000;
        if (block <= 6'h02) begin
            code = sum[47:32];
        end else if (block <= 6'h0B) begin
            code = sum[45:30];
        end else if (block <= 6'h14) begin
            code = sum[43:28];
        end else if (block <= 6'h1D) begin
            code = sum[41:26];
        end else begin
            code = sum[39:24];
        end
        return code;
    endfunction : energy_code

    // limits a programmed end bound to the largest value of the standard
    function automatic flcsr_coord_type clamp(input flcsr_coord_type value, input flcsr_coord_type limit);
        return (value > limit) ? limit : value;
    endfunction : clamp

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [3:0] encode_fill_level;
    logic [3:0] decode_drain_level;
    flcsr_coord_type col_first_value;
    flcsr_coord_type col_last_value;
    flcsr_coord_type line_first_value;
    flcsr_coord_type line_last_value;
    flcsr_code_type block_energy_code [ENERGY_BLOCKS];
    flcsr_code_type luma_sum_value;
    flcsr_code_type blue_diff_sum_value;
    flcsr_code_type red_diff_sum_value;
    flcsr_code_type luma_min_value;
    flcsr_code_type luma_max_value;

    // write decode
    wire wr_levels = REG_WRITE && (REG_INDEX == `FLCSR_IDX_FIFO_LEVELS);
    wire wr_col_first = REG_WRITE && (REG_INDEX == `FLCSR_IDX_COL_FIRST);
    wire wr_col_last = REG_WRITE && (REG_INDEX == `FLCSR_IDX_COL_LAST);
    wire wr_line_first = REG_WRITE && (REG_INDEX == `FLCSR_IDX_LINE_FIRST);
    wire wr_line_last = REG_WRITE && (REG_INDEX == `FLCSR_IDX_LINE_LAST);

    // ****************************************************************
    // host writes
    // ****************************************************************

    // fifo service levels, reserved bits 15:8 are dropped
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            encode_fill_level <= `FLCSR_ENC_LEVEL_RESET;
            decode_drain_level <= `FLCSR_DEC_LEVEL_RESET;
        end else if (wr_levels) begin
            encode_fill_level <= REG_WDATA[`FLCSR_ENC_LEVEL_MSB:`FLCSR_ENC_LEVEL_LSB];
            decode_drain_level <= REG_WDATA[`FLCSR_DEC_LEVEL_MSB:`FLCSR_DEC_LEVEL_LSB];
        end
    end

    // window bounds keep bits 9:0, upper reserved bits are dropped
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            col_first_value <= `FLCSR_COL_FIRST_RESET;
            col_last_value <= `FLCSR_COL_LAST_RESET;
            line_first_value <= `FLCSR_LINE_FIRST_RESET;
            line_last_value <= `FLCSR_LINE_LAST_RESET;
        end else begin
            if (wr_col_first) begin
                col_first_value <= REG_WDATA[9:0];
            end
            if (wr_col_last) begin
                col_last_value <= REG_WDATA[9:0];
            end
            // rewritten by the host each field for vertical cropping
            if (wr_line_first) begin
                line_first_value <= REG_WDATA[9:0];
            end
            if (wr_line_last) begin
                line_last_value <= REG_WDATA[9:0];
            end
        end
    end

    // ****************************************************************
    // fifo service request
    // ****************************************************************

    // thresholds in fifo positions, level times the 32-position step
    wire logic [9:0] encode_threshold = {1'b0, encode_fill_level, 5'h00};
    wire logic [9:0] decode_threshold = {1'b0, decode_drain_level, 5'h00};
    wire logic [9:0] fifo_depth = 10'(FIFO_DEPTH);
    wire logic [9:0] fifo_empty = fifo_depth - FIFO_FILL;
    wire encode_request = (encode_fill_level != 4'h0) && (FIFO_FILL >= encode_threshold);
    wire decode_request = (decode_drain_level != 4'h0) && (fifo_empty >= decode_threshold);
    wire next_service_request = ENCODE_MODE ? encode_request : decode_request;

    // level output, recomputed every cycle with no latching
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            FIFO_SERVICE_REQUEST_PIN <= 1'b0;
            FIFO_SERVICE_REQUEST_FLAG <= 1'b0;
        end else begin
            FIFO_SERVICE_REQUEST_PIN <= next_service_request;
            FIFO_SERVICE_REQUEST_FLAG <= next_service_request;
        end
    end

    // ****************************************************************
    // statistics capture
    // ****************************************************************

    // each arriving block sum is reduced to its code at once
    always_ff @(posedge CLK) begin
        if (ENERGY_VALID && (ENERGY_BLOCK < 6'(ENERGY_BLOCKS))) begin
            block_energy_code[ENERGY_BLOCK] <= energy_code(ENERGY_BLOCK, ENERGY_SUM);
        end
    end

    // component sums are taken when the transform announces a refresh
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            luma_sum_value <= 16'h0000;
            blue_diff_sum_value <= 16'h0000;
            red_diff_sum_value <= 16'h0000;
        end else if (STATS_REFRESH) begin
            luma_sum_value <= LUMA_SUM_IN;
            blue_diff_sum_value <= BLUE_SUM_IN;
            red_diff_sum_value <= RED_SUM_IN;
        end
    end

    // ready flag: refresh edge sets, status read clears, set wins a tie
    logic refresh_seen;
    wire refresh_edge = STATS_REFRESH && !refresh_seen;
    wire next_stats_ready = refresh_edge || (STATS_READY_STATUS && !STATUS_READ);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            refresh_seen <= 1'b0;
            STATS_READY_STATUS <= 1'b0;
            STATS_READY_PIN <= 1'b0;
        end else begin
            refresh_seen <= STATS_REFRESH;
            STATS_READY_STATUS <= next_stats_ready;
            STATS_READY_PIN <= next_stats_ready;
        end
    end

    // ****************************************************************
    // luma extremes and cropping
    // ****************************************************************

    // extremes are taken from pixels before the window is applied
    flcsr_luma_range #(
        .DATA_W(DATA_W)
    ) u_range (
        .clk(CLK),
        .reset(RESET),
        .field_start(FIELD_START),
        .pix_valid(PIX_VALID),
        .pix_comp(PIX_COMP),
        .pix_data(PIX_DATA),
        .luma_min(luma_min_value),
        .luma_max(luma_max_value)
    );

    // end bounds are limited to the selected standard
    wire flcsr_coord_type line_limit = MODE_625 ? `FLCSR_LINES_625 : `FLCSR_LINES_525;
    wire flcsr_coord_type col_limit = `FLCSR_COL_MAX;
    wire flcsr_coord_type col_last_eff = clamp(col_last_value, col_limit);
    wire flcsr_coord_type line_last_eff = clamp(line_last_value, line_limit);

    flcsr_crop #(
        .DATA_W(DATA_W)
    ) u_crop (
        .clk(CLK),
        .reset(RESET),
        .encode(ENCODE_MODE),
        .col_first(col_first_value),
        .col_last(col_last_eff),
        .line_first(line_first_value),
        .line_last(line_last_eff),
        .pix_valid(PIX_VALID),
        .pix_col(PIX_COL),
        .pix_line(PIX_LINE),
        .pix_comp(PIX_COMP),
        .pix_data(PIX_DATA),
        .out_valid(PIX_OUT_VALID),
        .out_comp(PIX_OUT_COMP),
        .out_data(PIX_OUT_DATA)
    );

    // ****************************************************************
    // host reads
    // ****************************************************************

    // energy range decode and the block it selects
    wire logic [9:0] energy_offset = REG_INDEX - `FLCSR_IDX_ENERGY_BASE;
    wire in_energy = (REG_INDEX >= `FLCSR_IDX_ENERGY_BASE) && (REG_INDEX <= `FLCSR_IDX_ENERGY_LAST);
    wire logic [5:0] energy_sel = energy_offset[5:0];
    wire flcsr_code_type energy_word = in_energy ? block_energy_code[energy_sel] : 16'h0000;

    // read selection; window bounds are write only and read as zero
    logic [15:0] read_word;
    always_comb begin
        read_word = 16'h0000;
        unique case (REG_INDEX)
            `FLCSR_IDX_FIFO_LEVELS: read_word = {8'h00, decode_drain_level, encode_fill_level};
            `FLCSR_IDX_LUMA_SUM: read_word = luma_sum_value;
            `FLCSR_IDX_BLUE_SUM: read_word = blue_diff_sum_value;
            `FLCSR_IDX_RED_SUM: read_word = red_diff_sum_value;
            `FLCSR_IDX_LUMA_MIN: read_word = luma_min_value;
            `FLCSR_IDX_LUMA_MAX: read_word = luma_max_value;
            default: read_word = energy_word;
        endcase
    end

    // reads have no side effect on any statistic, answer one cycle later
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= 32'h00000000;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_READ;
            if (REG_READ) begin
                REG_RDATA <= {16'h0000, read_word};
            end
        end
    end

endmodule : flcsr_regs

// [sim/flcsr_regs_props.sv]
// checker of the register bank ports, attached by bind
// assumes one CLK domain, RESET asynchronous active high
module flcsr_regs_props #(
    parameter int DATA_W = 8
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic REG_READ,
    input wire logic [31:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic STATUS_READ,
    input wire logic ENCODE_MODE,
    input wire logic [9:0] FIFO_FILL,
    input wire logic FIFO_SERVICE_REQUEST_PIN,
    input wire logic FIFO_SERVICE_REQUEST_FLAG,
    input wire logic STATS_REFRESH,
    input wire logic STATS_READY_PIN,
    input wire logic STATS_READY_STATUS,
    input wire logic PIX_VALID,
    input wire flcsr_pkg::flcsr_coord_type PIX_COL,
    input wire flcsr_pkg::flcsr_comp_type PIX_COMP,
    input wire logic [DATA_W-1:0] PIX_DATA,
    input wire logic PIX_OUT_VALID,
    input wire logic [DATA_W-1:0] PIX_OUT_DATA
);
    timeunit 1ns;
    timeprecision 1ps;
    import flcsr_pkg::*;
    // ****
    // port properties
    // ****
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_rd; REG_READ |=> REG_RVALID && REG_RDATA[31:16] == 16'h0000; endproperty
    a_rd: assert property (p_rd)
        else $error("read answer missing");
    property p_enc_empty; (ENCODE_MODE && FIFO_FILL == 10'h000) [*2] |-> !FIFO_SERVICE_REQUEST_PIN; endproperty
    a_enc_empty: assert property (p_enc_empty)
        else $error("encode request with empty fifo");
    property p_dec_full; (!ENCODE_MODE && FIFO_FILL == 10'h200) [*2] |-> !FIFO_SERVICE_REQUEST_PIN; endproperty
    a_dec_full: assert property (p_dec_full)
        else $error("decode request with full fifo");
    property p_flag; FIFO_SERVICE_REQUEST_PIN == FIFO_SERVICE_REQUEST_FLAG; endproperty
    a_flag: assert property (p_flag)
        else $error("request flag differs from pin");
    property p_rdy_set; $rose(STATS_REFRESH) |=> STATS_READY_PIN && STATS_READY_STATUS; endproperty
    a_rdy_set: assert property (p_rdy_set)
        else $error("ready not set");
    property p_rdy_hold; STATS_READY_PIN && !STATUS_READ |=> STATS_READY_PIN; endproperty
    a_rdy_hold: assert property (p_rdy_hold)
        else $error("ready dropped");
    property p_rdy_clr; STATUS_READ && !STATS_REFRESH |=> !STATS_READY_PIN; endproperty
    a_rdy_clr: assert property (p_rdy_clr)
        else $error("ready not cleared");
    property p_black;
        ENCODE_MODE && PIX_VALID && PIX_COMP == FLCSR_COMP_LUMA && PIX_COL > 10'h2CF
            |=> PIX_OUT_VALID && PIX_OUT_DATA == 8'h10;
    endproperty
    a_black: assert property (p_black)
        else $error("pixel past line end not black");
    property p_pass; !ENCODE_MODE && PIX_VALID |=> PIX_OUT_DATA == $past(PIX_DATA); endproperty
    a_pass: assert property (p_pass)
        else $error("decode pixel altered");
endmodule : flcsr_regs_props

bind flcsr_regs flcsr_regs_props #(.DATA_W(DATA_W)) u_props (
    .CLK(CLK), .RESET(RESET), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .STATUS_READ(STATUS_READ), .ENCODE_MODE(ENCODE_MODE), .FIFO_FILL(FIFO_FILL),
    .FIFO_SERVICE_REQUEST_PIN(FIFO_SERVICE_REQUEST_PIN), .FIFO_SERVICE_REQUEST_FLAG(FIFO_SERVICE_REQUEST_FLAG),
    .STATS_REFRESH(STATS_REFRESH), .STATS_READY_PIN(STATS_READY_PIN), .STATS_READY_STATUS(STATS_READY_STATUS),
    .PIX_VALID(PIX_VALID), .PIX_COL(PIX_COL), .PIX_COMP(PIX_COMP), .PIX_DATA(PIX_DATA),
    .PIX_OUT_VALID(PIX_OUT_VALID), .PIX_OUT_DATA(PIX_OUT_DATA)
);

// [sim/flcsr_host.sv]
// host model: indirect register writes, reads and status reads
// assumes its tasks are called just after a rising clk edge
module flcsr_host (
    input wire logic clk,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    output logic [9:0] index = 10'h000,
    output logic [15:0] wdata = 16'h0000,
    output logic wr = 1'b0,
    output logic rd = 1'b0,
    output logic st = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // one write strobe, then an idle edge
    task automatic write_reg(input logic [9:0] i, input logic [15:0] d);
        index <= i;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : write_reg
    // read strobe, answer taken under a bound
    task automatic read_reg(input logic [9:0] i, output logic [31:0] d);
        d = 'x;
        index <= i;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        repeat (3) begin
            @(posedge clk);
            if (rvalid === 1'b1) d = rdata;
        end
    endtask : read_reg
    // status register read, clears the ready flag
    task automatic status_pulse();
        st <= 1'b1;
        @(posedge clk);
        st <= 1'b0;
        @(posedge clk);
    endtask : status_pulse
    // window for the next field, rewritten each field
    task automatic set_window(input logic [9:0] cf, cl, lf, ll);
        write_reg(10'h002, {6'h00, cf});
        write_reg(10'h003, {6'h00, cl});
        write_reg(10'h004, {6'h00, lf});
        write_reg(10'h005, {6'h00, ll});
    endtask : set_window
endmodule : flcsr_host

// [sim/tb_top.sv]
// self-checking bench: fifo levels, statistics, cropping, luma range
// assumes flcsr_regs, its bound checker and flcsr_host compiled first
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
    end \
end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import flcsr_pkg::*;
    logic clk = 1'b0, reset = 1'b1, enc = 1'b1, pal = 1'b0, e_val = 1'b0, refresh = 1'b0;
    logic fstart = 1'b0, pvalid = 1'b0, wr, rd, st, rvalid, req_pin, req_flag, rdy_pin, rdy_st, ovalid;
    logic [9:0] fill = 10'h000, pcol = 10'h000, pline = 10'h000, index;
    logic [5:0] e_blk = 6'h00;
    logic [47:0] e_sum = 48'h000000000000;
    logic [15:0] s_luma = 16'h0000, s_blue = 16'h0000, s_red = 16'h0000, wdata;
    logic [7:0] pdata = 8'h00, odata;
    logic [31:0] rdata, d;
    flcsr_comp_type pcomp = FLCSR_COMP_LUMA, ocomp;
    int miscompares = 0, comparisons = 0;
    flcsr_regs DUT (
        .CLK(clk), .RESET(reset), .REG_INDEX(index), .REG_WDATA(wdata), .REG_WRITE(wr), .REG_READ(rd),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .STATUS_READ(st), .ENCODE_MODE(enc), .MODE_625(pal),
        .FIFO_FILL(fill), .FIFO_SERVICE_REQUEST_PIN(req_pin), .FIFO_SERVICE_REQUEST_FLAG(req_flag),
        .ENERGY_VALID(e_val), .ENERGY_BLOCK(e_blk), .ENERGY_SUM(e_sum), .STATS_REFRESH(refresh),
        .LUMA_SUM_IN(s_luma), .BLUE_SUM_IN(s_blue), .RED_SUM_IN(s_red), .STATS_READY_PIN(rdy_pin),
        .STATS_READY_STATUS(rdy_st), .FIELD_START(fstart), .PIX_VALID(pvalid), .PIX_COL(pcol),
        .PIX_LINE(pline), .PIX_COMP(pcomp), .PIX_DATA(pdata), .PIX_OUT_VALID(ovalid),
        .PIX_OUT_COMP(ocomp), .PIX_OUT_DATA(odata)
    );
    flcsr_host host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .index(index), .wdata(wdata),
        .wr(wr), .rd(rd), .st(st));
    // ****
    // expectations
    // ****
    function automatic logic exp_req(logic e, logic [3:0] le, logic [3:0] ld, int f);
        return e ? (le != 0 && f >= le * 32) : (ld != 0 && 512 - f >= ld * 32);
    endfunction : exp_req
    function automatic logic [15:0] exp_code(int b, logic [47:0] s);
        return 16'(s >> (b < 3 ? 32 : b < 12 ? 30 : b < 21 ? 28 : b < 30 ? 26 : 24));
    endfunction : exp_code
    function automatic logic [7:0] exp_pix(logic e, int c, int l, int m, flcsr_comp_type k, logic [7:0] v);
        if (!e || (c >= 10 && c <= 719 && l >= 5 && l <= m)) return v;
        return k == FLCSR_COMP_LUMA ? 8'h10 : 8'h00;
    endfunction : exp_pix
    // verdict and end of run
    task end_sim();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    // main sequence
    initial begin
        int i, e, f, c, l, mn, mx;
        logic [7:0] lv, v;
        logic [47:0] s;
        logic [10:0] ev;
        flcsr_comp_type pk;
        i = $urandom(99358);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        host.read_reg(10'h001, d);
        `CHK(d, 32'h00000088)
        host.read_reg(10'h002, d);
        `CHK(d, 32'h00000000)
        $display("reset values done");
        for (i = 0; i < 48; i++) begin
            lv = i == 0 ? 8'h08 : i == 1 ? 8'h80 : 8'($urandom);
            e = i % 2;
            host.write_reg(10'h001, {8'hFF, lv});
            host.read_reg(10'h001, d);
            `CHK(d, {24'h000000, lv})
            f = e ? lv[3:0] * 32 : 512 - lv[7:4] * 32;
            if (i % 4 == 1) f = e ? f - 1 : f + 1;
            if (i % 4 == 3) f = $urandom % 513;
            f = f < 0 ? 0 : f > 512 ? 512 : f;
            fill <= 10'(f);
            enc <= 1'(e);
            repeat (2) @(posedge clk);
            `CHK({req_pin, req_flag}, {2{exp_req(1'(e), lv[3:0], lv[7:4], f)}})
        end
        $display("fifo levels done");
        for (i = 0; i < 42; i++) begin
            s = 48'({$urandom, $urandom});
            e_val <= 1'b1;
            e_blk <= 6'(i);
            e_sum <= s;
            @(posedge clk);
            e_val <= 1'b0;
            host.read_reg(10'h080 + 10'(i), d);
            `CHK(d, {16'h0000, exp_code(i, s)})
        end
        s_luma <= 16'($urandom);
        s_blue <= 16'($urandom);
        s_red <= 16'($urandom);
        refresh <= 1'b1;
        @(posedge clk);
        refresh <= 1'b0;
        @(posedge clk);
        `CHK({rdy_pin, rdy_st}, 2'b11)
        host.read_reg(10'h0AA, d);
        `CHK(d, {16'h0000, s_luma})
        host.read_reg(10'h0AB, d);
        `CHK(d, {16'h0000, s_blue})
        host.read_reg(10'h0AC, d);
        `CHK(d, {16'h0000, s_red})
        `CHK({rdy_pin, rdy_st}, 2'b11)
        host.status_pulse();
        `CHK({rdy_pin, rdy_st}, 2'b00)
        $display("statistics done");
        host.set_window(10'd10, 10'h3FF, 10'd5, 10'h3FF);
        mn = 255;
        mx = 0;
        for (i = 0; i <= 60; i++) begin
            e = i < 30;
            c = $urandom % 2 ? $urandom % 21 : 715 + $urandom % 10;
            l = $urandom % 2 ? 3 + $urandom % 6 : 522 + $urandom % 7 + (i % 2) * 100;
            pk = i % 3 == 0 ? FLCSR_COMP_LUMA : i % 3 == 1 ? FLCSR_COMP_BLUE : FLCSR_COMP_RED;
            v = 8'($urandom);
            if (i < 60 && i % 3 == 0) mn = v < mn ? v : mn;
            if (i < 60 && i % 3 == 0) mx = v > mx ? v : mx;
            fstart <= i % 60 == 0;
            pvalid <= 1'b1;
            pcol <= 10'(c);
            pline <= 10'(l);
            pcomp <= pk;
            pdata <= v;
            enc <= 1'(e);
            pal <= 1'(i % 2);
            @(posedge clk);
            if (i > 0) `CHK({ovalid, ocomp, odata}, ev)
            ev = {1'b1, pk, exp_pix(1'(e), c, l, i % 2 ? 625 : 525, pk, v)};
        end
        pvalid <= 1'b0;
        fstart <= 1'b0;
        @(posedge clk);
        `CHK({ovalid, ocomp, odata}, ev)
        host.read_reg(10'h0AD, d);
        `CHK(d, 32'(mn))
        host.read_reg(10'h0AE, d);
        `CHK(d, 32'(mx))
        $display("crop and luma range done");
        end_sim();
    end
endmodule : tb_top
